// ===== rtl/rsr_consts.svh
`ifndef RSR_CONSTS_SVH
`define RSR_CONSTS_SVH
// register indices of the status bank
`define RSR_IDX_PHASE_ADJ   4'h0
`define RSR_IDX_PART_ID     4'h1
`define RSR_IDX_PART_REV    4'h2
`define RSR_IDX_PIN_LINK    4'h3
`define RSR_IDX_RX_PRE      4'h4
`define RSR_IDX_TX_SYNC     4'h5
`define RSR_IDX_WAKE        4'h6
`define RSR_IDX_CTRL_FLAGS  4'h7
`define RSR_IDX_AMP_TEST    4'h8
`define RSR_IDX_SYN_TEST    4'h9
`define RSR_IDX_PRE_TEST    4'ha
`define RSR_IDX_PRESCALER_OVERRIDE_RESERVED     4'hb
`define RSR_IDX_ADC_TEST    4'hc
`define RSR_IDX_DIVIDER_CHAIN_TEST_RESERVED    4'hd
// field positions
`define RSR_B_MEM_SEL       5
`define RSR_B_SLOW_CLK      4
`define RSR_B_SYNC_EN       3
`define RSR_B_MOD_CLK       2
`define RSR_B_SER_DATA      1
`define RSR_B_SER_CLK       0
`define RSR_B_SYNC_FOUND    7
`define RSR_B_RX_FULL       6
`define RSR_B_RX_LEVEL      5
`define RSR_B_RX_EMPTY      4
`define RSR_B_RX_OVR        3
`define RSR_B_RX_UND        2
`define RSR_B_PRE_DET       1
`define RSR_B_PQ_VALID      0
`define RSR_B_FEC_OVR       6
`define RSR_B_SYNC_SENT     4
`define RSR_B_TX_FULL       3
`define RSR_B_TX_LEVEL      2
`define RSR_B_TX_OVR        1
`define RSR_B_TX_UND        0
`define RSR_B_CCA_FAIL      2
`define RSR_B_CAL_VALID     0
// writable masks and reset values
`define RSR_PIN_WMASK       8'h28
`define RSR_AMP_WMASK       8'h1f
`define RSR_SYN_WMASK       8'h7f
`define RSR_PRE_WMASK       8'h1f
`define RSR_ADC_WMASK       8'h3f
`define RSR_DVC_WMASK       8'h1f
`define RSR_DVC_RST         8'h0b
`define RSR_RST_ZERO        8'h00
// timing
`define RSR_PRE_LOSS_EXTRA  10
`define RSR_MOD_OVERSAMPLE  16
`endif

// ===== rtl/rsr_pkg.sv
package rsr_pkg;
  typedef enum logic [7:0] {
    RSR_WC_NONE     = 8'h00,
    RSR_WC_RX_TMO   = 8'h01,
    RSR_WC_RX_TERM  = 8'h02,
    RSR_WC_WAKE_LOS = 8'h03,
    RSR_WC_LEN_DISC = 8'h04,
    RSR_WC_ADR_DISC = 8'h05,
    RSR_WC_CRC_DISC = 8'h06,
    RSR_WC_TX_OVR   = 8'h07,
    RSR_WC_TX_UND   = 8'h08,
    RSR_WC_RX_OVR   = 8'h09,
    RSR_WC_RX_UND   = 8'h0a,
    RSR_WC_CCA_FAIL = 8'h0b,
    RSR_WC_TX_OK    = 8'h40,
    RSR_WC_RX_OK    = 8'h80
  } rsr_wake_code_t;

  typedef enum logic [2:0] {
    RSR_PS_IDLE  = 3'b001,
    RSR_PS_HELD  = 3'b010,
    RSR_PS_LOSS  = 3'b100
  } rsr_pre_state_t;

  // register port request from the serial control port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] idx;
    logic [7:0] wdata;
  } rsr_req_t;

  // events and levels from the radio core
  typedef struct packed {
    logic [7:0] rx_count;
    logic [7:0] tx_count;
    logic       rx_push;
    logic       rx_pop;
    logic       rx_flush;
    logic       tx_push;
    logic       tx_empty_early;
    logic       tx_flush;
    logic       sync_event;
    logic       rx_strobe;
    logic       pre_below_thr;
    logic       rx_bit;
    logic       fec_overrun;
    logic       sync_sent;
    logic       cca_done;
    logic       cca_busy;
    logic       cal_done;
    logic       wake_event;
    logic [7:0] wake_code;
  } rsr_core_t;
endpackage

// ===== rtl/rsr_status_regs.sv
`include "rsr_consts.svh"

// Summary of operation
// [RULE_01] memory select bit 0 steers direct access to buffers, 1 to workspace area
// [RULE_02] pins are synchronised only while the synchroniser enable bit is set
// [RULE_03] read-only soft modulator clock toggles at sixteen times symbol rate
// [RULE_04] live views of slow rc clock, serial data and serial clock
// [RULE_05] sync found sets with sync event, clears only on receive strobe
// [RULE_06] rx full sets above threshold, clears only when rx buffer empties
// [RULE_07] rx level flag follows count above threshold
// [RULE_08] rx empty flag is high while rx buffer holds nothing
// [RULE_09] rx overrun sets on push into full buffer, held until flush
// [RULE_10] rx underrun sets on read from empty buffer, held until flush
// [RULE_11] preamble flag holds with preamble, clears on sync or after timeout
// [RULE_12] qualifier valid resets high, sets after selected bit count or detection
// [RULE_13] read-only flags for error-correction overrun and sync word sent
// [RULE_14] tx full sets when full, clears when count below threshold
// [RULE_15] tx level flag set while count at or above threshold
// [RULE_16] tx overrun sets on write into full buffer, held until flush
// [RULE_17] tx underrun sets when buffer empties mid packet, held until flush
// [RULE_18] wake cause codes 0 to 6 for receive failures and discards
// [RULE_19] wake cause codes 7 to 11 for buffer faults and failed clear check
// [RULE_20] wake cause 0x40 for transmit done, 0x80 for packet received
// [RULE_21] wake cause is held for the host to read after wake signal
// [RULE_22] clear check failed bit reads 0 when clear, 1 when busy
// [RULE_23] calibration valid bit sets once oscillator calibrated
// [RULE_24] writes to read-only and unused bits are ignored
module rsr_status_regs #(
  parameter int         DEPTH     = 128,
  parameter logic [7:0] PART_ID   = 8'h5a, // arbitrary neutral value
  parameter logic [7:0] PART_REV  = 8'h01, // arbitrary neutral value
  parameter logic [7:0] SYNC_BITS = 8'h20
) (
  input  wire logic             mclk,          // 100 mhz clock
  input  wire logic             rst_n,         // synchronous reset
  input  wire rsr_pkg::rsr_req_t req,          // register access request
  output logic [7:0]            rdata,         // read data, registered
  output logic                  rvalid,        // read data valid pulse
  input  wire rsr_pkg::rsr_core_t core,        // radio core events
  input  wire logic [7:0]       rx_thr,        // rx buffer threshold
  input  wire logic [7:0]       tx_thr,        // tx buffer threshold
  input  wire logic [2:0]       pq_tmo_sel,    // qualifier valid timeout select
  input  wire logic [15:0]      sym_div,       // mclk cycles per modulator tick, minus one
  input  wire logic             slow_rc_clk,   // 40 khz rc oscillator
  input  wire logic             ser_rx_data,   // serial rx data
  input  wire logic             ser_rx_clk,    // serial rx clock
  input  wire logic [3:0]       gpio_in,       // general purpose pins
  output logic                  mem_target_sel, // direct access target
  output logic                  pin_sync_en,   // synchroniser enable
  output logic [3:0]            gpio_state,    // synchronised pin view
  output logic                  soft_mod_clk,  // soft modulator clock
  output logic                  host_wake      // host wake signal
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic wr_pin = req.wr && (req.idx == `RSR_IDX_PIN_LINK);
  wire logic wr_amp = req.wr && (req.idx == `RSR_IDX_AMP_TEST);
  wire logic wr_syn = req.wr && (req.idx == `RSR_IDX_SYN_TEST);
  wire logic wr_pre = req.wr && (req.idx == `RSR_IDX_PRE_TEST);
  wire logic wr_ovr = req.wr && (req.idx == `RSR_IDX_PRESCALER_OVERRIDE_RESERVED);
  wire logic wr_adc = req.wr && (req.idx == `RSR_IDX_ADC_TEST);
  wire logic wr_dvc = req.wr && (req.idx == `RSR_IDX_DIVIDER_CHAIN_TEST_RESERVED);

  logic [7:0] pin_ctl_r, amp_r, syn_r, pre_r, ovr_r, adc_r, dvc_r;

  // only documented writable bits are stored; others are dropped
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_ctl_r <= `RSR_RST_ZERO;
      amp_r     <= `RSR_RST_ZERO;
      syn_r     <= `RSR_RST_ZERO;
      pre_r     <= `RSR_RST_ZERO;
      ovr_r     <= `RSR_RST_ZERO;
      adc_r     <= `RSR_RST_ZERO;
      dvc_r     <= `RSR_DVC_RST;
    end else begin
      if (wr_pin) pin_ctl_r <= req.wdata & `RSR_PIN_WMASK; // [RULE_24]
      if (wr_amp) amp_r <= req.wdata & `RSR_AMP_WMASK;     // [RULE_24]
      if (wr_syn) syn_r <= req.wdata & `RSR_SYN_WMASK;
      if (wr_pre) pre_r <= req.wdata & `RSR_PRE_WMASK;
      if (wr_ovr) ovr_r <= req.wdata;
      if (wr_adc) adc_r <= req.wdata & `RSR_ADC_WMASK;
      if (wr_dvc) dvc_r <= req.wdata & `RSR_DVC_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // pin synchroniser and live views
  // ---------------------------------------------------------------
  wire logic sync_on = pin_ctl_r[`RSR_B_SYNC_EN];
  logic [3:0] gpio_s1_r, gpio_s2_r;
  logic [2:0] view_s1_r, view_s2_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gpio_s1_r <= 4'h0;
      gpio_s2_r <= 4'h0;
    end else if (sync_on) begin          // [RULE_02]
      gpio_s1_r <= gpio_in;
      gpio_s2_r <= gpio_s1_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      view_s1_r <= 3'h0;
      view_s2_r <= 3'h0;
    end else begin
      view_s1_r <= {slow_rc_clk, ser_rx_data, ser_rx_clk}; // [RULE_04]
      view_s2_r <= view_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // soft modulator clock: toggles on an enable pulse from a divider
  // ---------------------------------------------------------------
  logic [15:0] mod_cnt_r;
  logic        mod_clk_r;
  wire  logic  mod_tick = (mod_cnt_r == 16'h0000);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mod_cnt_r <= 16'h0000;
      mod_clk_r <= 1'b0;
    end else begin
      mod_cnt_r <= mod_tick ? sym_div : mod_cnt_r - 16'h0001;
      if (mod_tick) mod_clk_r <= ~mod_clk_r;  // [RULE_03]
    end
  end

  // ---------------------------------------------------------------
  // rx buffer flags
  // ---------------------------------------------------------------
  wire logic rx_is_empty = (core.rx_count == 8'h00);
  wire logic rx_is_full  = ({24'h0, core.rx_count} >= DEPTH);
  wire logic rx_above    = (core.rx_count > rx_thr);
  logic sync_found_r, rx_full_r, rx_ovr_r, rx_und_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync_found_r <= 1'b0;
      rx_full_r    <= 1'b0;
      rx_ovr_r     <= 1'b0;
      rx_und_r     <= 1'b0;
    end else begin
      // set wins over clear for every sticky flag
      if (core.sync_event) sync_found_r <= 1'b1;      // [RULE_05]
      else if (core.rx_strobe) sync_found_r <= 1'b0;  // [RULE_05]
      if (rx_above) rx_full_r <= 1'b1;                // [RULE_06]
      else if (rx_is_empty) rx_full_r <= 1'b0;        // [RULE_06]
      if (core.rx_push && rx_is_full) rx_ovr_r <= 1'b1; // [RULE_09]
      else if (core.rx_flush) rx_ovr_r <= 1'b0;
      if (core.rx_pop && rx_is_empty) rx_und_r <= 1'b1; // [RULE_10]
      else if (core.rx_flush) rx_und_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // preamble detection and qualifier valid
  // ---------------------------------------------------------------
  rsr_pkg::rsr_pre_state_t pst_r, pst_nxt;
  logic [8:0] loss_cnt_r;
  wire  logic [8:0] loss_len = {1'b0, SYNC_BITS} + 9'(`RSR_PRE_LOSS_EXTRA);
  wire  logic loss_done = (loss_cnt_r >= loss_len);

  always_comb begin
    pst_nxt = pst_r;
    case (pst_r)
      rsr_pkg::RSR_PS_IDLE: if (core.pre_below_thr && !core.sync_event)
        pst_nxt = rsr_pkg::RSR_PS_HELD;
      rsr_pkg::RSR_PS_HELD: begin
        if (core.sync_event) pst_nxt = rsr_pkg::RSR_PS_IDLE;     // [RULE_11]
        else if (!core.pre_below_thr) pst_nxt = rsr_pkg::RSR_PS_LOSS;
      end
      rsr_pkg::RSR_PS_LOSS: begin
        if (core.sync_event || loss_done) pst_nxt = rsr_pkg::RSR_PS_IDLE; // [RULE_11]
        else if (core.pre_below_thr) pst_nxt = rsr_pkg::RSR_PS_HELD;
      end
      default: pst_nxt = rsr_pkg::RSR_PS_IDLE;
    endcase
  end

  // loss timeout counted in received symbols
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pst_r      <= rsr_pkg::RSR_PS_IDLE;
      loss_cnt_r <= 9'h000;
    end else begin
      pst_r <= pst_nxt;
      if (pst_r != rsr_pkg::RSR_PS_LOSS) loss_cnt_r <= 9'h000;
      else if (core.rx_bit) loss_cnt_r <= loss_cnt_r + 9'h001;
    end
  end

  wire logic pre_det = (pst_r != rsr_pkg::RSR_PS_IDLE);

  logic [5:0] pq_limit;
  always_comb begin
    case (pq_tmo_sel)
      3'h0:    pq_limit = 6'd11;
      3'h1:    pq_limit = 6'd12;
      3'h2:    pq_limit = 6'd13;
      3'h3:    pq_limit = 6'd14;
      3'h4:    pq_limit = 6'd15;
      3'h5:    pq_limit = 6'd17;
      3'h6:    pq_limit = 6'd24;
      default: pq_limit = 6'd32;
    endcase
  end

  // count restarts with each receive command; valid resets high
  logic [5:0] pq_cnt_r;
  logic       pq_valid_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pq_cnt_r   <= 6'h00;
      pq_valid_r <= 1'b1;                                  // [RULE_12]
    end else if (core.rx_strobe) begin
      pq_cnt_r   <= 6'h00;
      pq_valid_r <= 1'b0;
    end else begin
      if (core.rx_bit && !pq_valid_r) pq_cnt_r <= pq_cnt_r + 6'h01;
      if (pre_det || (core.rx_bit && (pq_cnt_r + 6'h01 >= pq_limit)))
        pq_valid_r <= 1'b1;                                // [RULE_12]
    end
  end

  // ---------------------------------------------------------------
  // tx buffer flags and radio control flags
  // ---------------------------------------------------------------
  wire logic tx_is_full = ({24'h0, core.tx_count} >= DEPTH);
  wire logic tx_at_thr  = (core.tx_count >= tx_thr);
  logic tx_full_r, tx_ovr_r, tx_und_r, fec_ovr_r, sync_sent_r, cca_fail_r, cal_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_full_r   <= 1'b0;
      tx_ovr_r    <= 1'b0;
      tx_und_r    <= 1'b0;
      fec_ovr_r   <= 1'b0;
      sync_sent_r <= 1'b0;
      cca_fail_r  <= 1'b0;
      cal_r       <= 1'b0;
    end else begin
      if (tx_is_full) tx_full_r <= 1'b1;                       // [RULE_14]
      else if (!tx_at_thr) tx_full_r <= 1'b0;                  // [RULE_14]
      if (core.tx_push && tx_is_full) tx_ovr_r <= 1'b1;        // [RULE_16]
      else if (core.tx_flush) tx_ovr_r <= 1'b0;
      if (core.tx_empty_early) tx_und_r <= 1'b1;               // [RULE_17]
      else if (core.tx_flush) tx_und_r <= 1'b0;
      fec_ovr_r   <= core.fec_overrun;                         // [RULE_13]
      sync_sent_r <= core.sync_sent;                           // [RULE_13]
      if (core.cca_done) cca_fail_r <= core.cca_busy;          // [RULE_22]
      if (core.cal_done) cal_r <= 1'b1;                        // [RULE_23]
    end
  end

  // ---------------------------------------------------------------
  // wake cause: code captured with each wake event and held
  // ---------------------------------------------------------------
  logic [7:0] wake_r;
  logic       wake_r_pulse;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wake_r       <= rsr_pkg::RSR_WC_NONE;
      wake_r_pulse <= 1'b0;
    end else begin
      wake_r_pulse <= core.wake_event;
      // codes 0x00..0x0b, 0x40, 0x80 pass through unchanged
      if (core.wake_event) wake_r <= core.wake_code;           // [RULE_18] [RULE_19] [RULE_20] [RULE_21]
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire logic [7:0] pin_view = {2'b00, pin_ctl_r[`RSR_B_MEM_SEL], view_s2_r[2],
                               sync_on, mod_clk_r, view_s2_r[1:0]};
  wire logic [7:0] rx_view = {sync_found_r, rx_full_r, rx_above, rx_is_empty, // [RULE_07] [RULE_08]
                              rx_ovr_r, rx_und_r, pre_det, pq_valid_r};
  wire logic [7:0] tx_view = {1'b0, fec_ovr_r, 1'b0, sync_sent_r,
                              tx_full_r, tx_at_thr, tx_ovr_r, tx_und_r};  // [RULE_15]
  wire logic [7:0] ctl_view = {5'h00, cca_fail_r, 1'b0, cal_r};

  logic [7:0] rd_mux;
  always_comb begin
    case (req.idx)
      `RSR_IDX_PHASE_ADJ:  rd_mux = `RSR_RST_ZERO;
      `RSR_IDX_PART_ID:    rd_mux = PART_ID;
      `RSR_IDX_PART_REV:   rd_mux = PART_REV;
      `RSR_IDX_PIN_LINK:   rd_mux = pin_view;
      `RSR_IDX_RX_PRE:     rd_mux = rx_view;
      `RSR_IDX_TX_SYNC:    rd_mux = tx_view;
      `RSR_IDX_WAKE:       rd_mux = wake_r;
      `RSR_IDX_CTRL_FLAGS: rd_mux = ctl_view;
      `RSR_IDX_AMP_TEST:   rd_mux = amp_r;
      `RSR_IDX_SYN_TEST:   rd_mux = syn_r;
      `RSR_IDX_PRE_TEST:   rd_mux = pre_r;
      `RSR_IDX_PRESCALER_OVERRIDE_RESERVED:    rd_mux = ovr_r;
      `RSR_IDX_ADC_TEST:   rd_mux = adc_r;
      `RSR_IDX_DIVIDER_CHAIN_TEST_RESERVED:   rd_mux = dvc_r;
      default:             rd_mux = `RSR_RST_ZERO;
    endcase
  end

  // every top output is a flip-flop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata          <= `RSR_RST_ZERO;
      rvalid         <= 1'b0;
      mem_target_sel <= 1'b0;
      pin_sync_en    <= 1'b0;
      gpio_state     <= 4'h0;
      soft_mod_clk   <= 1'b0;
      host_wake      <= 1'b0;
    end else begin
      rvalid         <= req.rd;
      if (req.rd) rdata <= rd_mux;
      mem_target_sel <= pin_ctl_r[`RSR_B_MEM_SEL];            // [RULE_01]
      pin_sync_en    <= sync_on;
      gpio_state     <= sync_on ? gpio_s2_r : 4'h0;          // [RULE_02]
      soft_mod_clk   <= mod_clk_r;
      host_wake      <= wake_r_pulse;
    end
  end
endmodule

// ===== verif/rsr_monitor.sv
module rsr_monitor (
  input wire logic               mclk,           // clock
  input wire logic               rst_n,          // sync reset
  input wire rsr_pkg::rsr_req_t  req,            // register request
  input wire logic [7:0]         rdata,          // read data
  input wire rsr_pkg::rsr_core_t core,           // core events
  input wire logic [7:0]         rx_thr,         // rx threshold
  input wire logic [7:0]         tx_thr,         // tx threshold
  input wire logic               mem_target_sel, // access target
  input wire logic               pin_sync_en,    // sync enable
  input wire logic [3:0]         gpio_state,     // synced pins
  input wire logic               host_wake       // wake signal
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ------------------------------
  // event then read sequences and the host wake pulse
  // ------------------------------
  sequence s_wake_rd;
    core.wake_event ##2 (req.rd && req.idx == 4'h6);
  endsequence
  sequence s_sync_rd;
    core.sync_event ##2 (req.rd && req.idx == 4'h4);
  endsequence
  sequence s_wake_pulse;
    host_wake ##1 !host_wake;
  endsequence
  // ------------------------------
  // assertions
  // ------------------------------
  a_wake_pulse_timing: assert property (core.wake_event |-> ##2 s_wake_pulse)
    else $error("host wake is not one pulse two cycles after the event");
  a_wake_code_held: assert property (s_wake_rd |=> rdata == $past(core.wake_code, 3))
    else $error("wake cause read differs from the event code");
  a_sync_found_set: assert property (s_sync_rd |=> rdata[7])
    else $error("sync found flag not set after sync event");
  a_target_sel_write: assert property (req.wr && req.idx == 4'h3 |=>
    ##1 mem_target_sel == $past(req.wdata[5], 2))
    else $error("memory target select does not follow the write");
  a_gpio_sync_off: assert property (!pin_sync_en [*3] |-> gpio_state == 4'h0)
    else $error("pin view active while synchroniser disabled");
  a_rx_empty_view: assert property (req.rd && req.idx == 4'h4 && core.rx_count == 8'h00
    |=> rdata[4])
    else $error("rx empty flag low with empty buffer");
  a_rx_level_view: assert property (req.rd && req.idx == 4'h4 |=>
    rdata[5] == ($past(core.rx_count) > $past(rx_thr)))
    else $error("rx level flag disagrees with count");
  a_tx_level_view: assert property (req.rd && req.idx == 4'h5 |=>
    rdata[2] == ($past(core.tx_count) >= $past(tx_thr)))
    else $error("tx level flag disagrees with count");
endmodule

// ===== verif/rsr_host_model.sv
module rsr_host_model (
  input  wire logic         mclk,  // clock
  output rsr_pkg::rsr_req_t req,   // register request
  input  wire logic [7:0]   rdata, // read data
  input  wire logic         rvalid // read valid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req = '0;
  // one idle cycle follows each access so a strobe never falls and rises at once
  task automatic rd(input logic [3:0] i, output logic [7:0] d, output logic v);
    req.rd = 1'b1;
    req.idx = i;
    @(posedge mclk);
    #1;
    d = rdata;
    v = rvalid;
    req.rd = 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    req.wr = 1'b1;
    req.idx = i;
    req.wdata = d;
    @(posedge mclk);
    #1;
    req.wr = 1'b0;
    @(posedge mclk);
    #1;
  endtask
endmodule

// ===== verif/testbench.sv
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] PID = 8'h5a; // arbitrary value
  localparam logic [7:0] PRV = 8'h01; // arbitrary value
  localparam logic [7:0] SB = 8'h04;
  localparam logic [7:0] THR = 8'h08;
  localparam int DEPTH = 128;
  localparam int NB [8] = '{11, 12, 13, 14, 15, 17, 24, 32};
  localparam logic [7:0] WM [16] = '{8'h00, 8'h00, 8'h00, 8'h28, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h1f, 8'h7f, 8'h1f, 8'hff, 8'h3f, 8'h1f, 8'h00, 8'h00};
  localparam rsr_pkg::rsr_core_t LVL = '{rx_count: 8'hff, tx_count: 8'hff, pre_below_thr: 1'b1,
    fec_overrun: 1'b1, sync_sent: 1'b1, cca_busy: 1'b1, wake_code: 8'hff, default: '0};
  logic               mclk, rst_n, rvalid, mem_target_sel, pin_sync_en, soft_mod_clk, host_wake;
  logic               slow_rc_clk, ser_rx_data, ser_rx_clk;
  logic [7:0]         rdata, wk;
  logic [3:0]         gpio_in, gpio_state;
  logic [2:0]         pq_tmo_sel;
  logic [7:0]         wreg [16];
  rsr_pkg::rsr_req_t  req;
  rsr_pkg::rsr_core_t core;
  bit                 sf, rf, ro, ru, pd, pv, tf, tov, tu, fo, ss, cca, cal;
  int                 bc, lc, n, cyc, num_errors, n_checks;

  rsr_status_regs #(.DEPTH(DEPTH), .PART_ID(PID), .PART_REV(PRV), .SYNC_BITS(SB))
  i_rsr_status_regs (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .core(core), .rx_thr(THR), .tx_thr(THR), .pq_tmo_sel(pq_tmo_sel), .sym_div(16'h0004),
    .slow_rc_clk(slow_rc_clk), .ser_rx_data(ser_rx_data), .ser_rx_clk(ser_rx_clk),
    .gpio_in(gpio_in), .mem_target_sel(mem_target_sel), .pin_sync_en(pin_sync_en),
    .gpio_state(gpio_state), .soft_mod_clk(soft_mod_clk), .host_wake(host_wake));
  rsr_host_model host (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  // ------------------------------
  // reference model
  // ------------------------------
  function automatic logic [7:0] ex(input logic [3:0] i);
    case (i)
      4'h1: ex = PID;
      4'h2: ex = PRV;
      4'h3: ex = wreg[3] | {3'h0, slow_rc_clk, 2'h0, ser_rx_data, ser_rx_clk};
      4'h4: ex = {sf, rf, core.rx_count > THR, core.rx_count == 8'h00, ro, ru, pd, pv};
      4'h5: ex = {1'h0, fo, 1'h0, ss, tf, core.tx_count >= THR, tov, tu};
      4'h6: ex = wk;
      4'h7: ex = {5'h00, cca, 1'h0, cal};
      default: ex = wreg[i];
    endcase
  endfunction
  task automatic upd();
    bc = core.rx_strobe ? 0 : bc + int'(core.rx_bit);
    pv = !core.rx_strobe && (pv || bc >= NB[pq_tmo_sel] || core.pre_below_thr);
    lc = (core.pre_below_thr || !pd) ? 0 : lc + int'(core.rx_bit);
    pd = !core.sync_event && (core.pre_below_thr || (pd && lc < SB + 10));
    sf = core.sync_event || (sf && !core.rx_strobe);
    rf = (core.rx_count > THR) || (rf && core.rx_count != 8'h00);
    ro = (core.rx_push && core.rx_count >= DEPTH) || (ro && !core.rx_flush);
    ru = (core.rx_pop && core.rx_count == 8'h00) || (ru && !core.rx_flush);
    tf = (core.tx_count >= DEPTH) || (tf && core.tx_count >= THR);
    tov = (core.tx_push && core.tx_count >= DEPTH) || (tov && !core.tx_flush);
    tu = core.tx_empty_early || (tu && !core.tx_flush);
    fo = core.fec_overrun;
    ss = core.sync_sent;
    cca = core.cca_done ? core.cca_busy : cca;
    cal = cal || core.cal_done;
  endtask
  // ------------------------------
  // drivers and checks
  // ------------------------------
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  // pulses last one cycle; levels are kept
  task automatic step();
    upd();
    tick();
    core = core & LVL;
    tick();
  endtask
  task automatic bits(input int k);
    repeat (k) begin
      core.rx_bit = 1'b1;
      step();
    end
  endtask
  task automatic rdc(input logic [3:0] i);
    logic [7:0] d;
    logic       v;
    host.rd(i, d, v);
    // modulator clock bit runs free, it is checked by its own period
    if (i == 4'h3) d[2] = 1'b0;
    `CHK("read valid", 1'b1, v)
    `CHK($sformatf("reg %h", i), ex(i), d)
  endtask
  task automatic chk();
    rdc(4'h4);
    rdc(4'h5);
    rdc(4'h7);
  endtask
  task automatic lvl(input logic [7:0] rc, input logic [7:0] tc);
    core.rx_count = rc;
    core.tx_count = tc;
    step();
    chk();
  endtask
  task automatic wait_tog(output int cnt);
    logic m;
    m = soft_mod_clk;
    cnt = 0;
    do begin
      tick();
      cnt++;
    end while (soft_mod_clk === m && cnt < 200);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    logic [3:0] i;
    logic [7:0] d;
    rst_n = 1'b0;
    core = '0;
    {slow_rc_clk, ser_rx_data, ser_rx_clk} = 3'h0;
    gpio_in = 4'h0;
    pq_tmo_sel = 3'h0;
    pv = 1'b1;
    wk = 8'h00;
    foreach (wreg[j]) wreg[j] = 8'h00;
    wreg[13] = 8'h0b;
    void'($urandom(32'hb175b851));
    repeat (8) tick();
    rst_n = 1'b1;
    for (int j = 0; j < 16; j++) rdc(4'(j));
    done("reset");
    repeat (40) begin
      i = 4'($urandom);
      d = 8'($urandom);
      wreg[i] = (d & WM[i]) | (wreg[i] & ~WM[i]);
      host.wr(i, d);
      `CHK("target sel", wreg[3][5], mem_target_sel)
      rdc(i);
    end
    done("writes");
    repeat (4) begin
      host.wr(4'h3, 8'h00);
      wreg[3] = 8'h00;
      gpio_in = 4'($urandom);
      repeat (3) tick();
      `CHK("pins off", 4'h0, gpio_state)
      host.wr(4'h3, 8'h08);
      wreg[3] = 8'h08;
      {slow_rc_clk, ser_rx_data, ser_rx_clk} = 3'($urandom);
      repeat (3) tick();
      `CHK("pins on", gpio_in, gpio_state)
      `CHK("sync en", 1'b1, pin_sync_en)
      rdc(4'h3);
    end
    done("pins");
    wait_tog(n);
    wait_tog(n);
    `CHK("mod clock", 5, n)
    done("modclk");
    lvl(8'h09, 8'h00);
    lvl(8'h08, 8'h00);
    lvl(8'h01, 8'h00);
    lvl(8'h00, 8'h00);
    core.rx_pop = 1'b1;
    step();
    chk();
    core.rx_count = 8'h80;
    core.rx_push = 1'b1;
    step();
    chk();
    lvl(8'h05, 8'h00);
    core.rx_flush = 1'b1;
    step();
    chk();
    done("rx");
    core.tx_push = 1'b1;
    lvl(8'h00, 8'h80);
    lvl(8'h00, 8'h0a);
    lvl(8'h00, 8'h07);
    core.tx_empty_early = 1'b1;
    step();
    chk();
    core.tx_flush = 1'b1;
    step();
    chk();
    done("tx");
    {core.fec_overrun, core.sync_sent, core.cca_busy} = 3'h7;
    {core.cca_done, core.cal_done} = 2'h3;
    step();
    chk();
    {core.fec_overrun, core.cca_busy, core.cca_done} = 3'h1;
    step();
    chk();
    done("misc");
    core.pre_below_thr = 1'b1;
    step();
    chk();
    core.pre_below_thr = 1'b0;
    step();
    bits(SB + 9);
    chk();
    bits(1);
    chk();
    core.pre_below_thr = 1'b1;
    step();
    core.pre_below_thr = 1'b0;
    core.sync_event = 1'b1;
    step();
    chk();
    for (int k = 0; k < 8; k++) begin
      pq_tmo_sel = 3'(k);
      core.rx_strobe = 1'b1;
      step();
      bits(NB[k] - 1);
      chk();
      bits(1);
      chk();
    end
    done("preamble");
    for (int k = 0; k < 14; k++) begin
      wk = (k < 12) ? 8'(k) : (k == 12 ? 8'h40 : 8'h80);
      core.wake_code = wk;
      core.wake_event = 1'b1;
      tick();
      core.wake_event = 1'b0;
      tick();
      `CHK("wake pin", 1'b1, host_wake)
      rdc(4'h6);
    end
    done("wake");
    end_sim();
  end
endmodule

bind rsr_status_regs rsr_monitor u_mon (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata),
  .core(core), .rx_thr(rx_thr), .tx_thr(tx_thr), .mem_target_sel(mem_target_sel),
  .pin_sync_en(pin_sync_en), .gpio_state(gpio_state), .host_wake(host_wake));
